// ==== design/frtcs_pkg.sv ====
package frtcs_pkg;

	// ==========================================================
	// register byte addresses on apb
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_COUNTER = 8'h08;
	localparam logic [7:0] ADDR_CMP_A = 8'h0C;
	localparam logic [7:0] ADDR_CMP_B = 8'h10;
	localparam logic [7:0] ADDR_CAPTURE = 8'h14;
	localparam logic [7:0] ADDR_SERVICE = 8'h18;

	// ==========================================================
	// control field positions
	localparam int CTL_CAP_IE = 7;
	localparam int CTL_CMPB_IE = 6;
	localparam int CTL_CMPA_IE = 5;
	localparam int CTL_WRAP_IE = 4;
	localparam int CTL_CMPB_OE = 3;
	localparam int CTL_CMPA_OE = 2;
	localparam int CTL_CKS_HI = 1;
	localparam int CTL_CKS_LO = 0;

	// ==========================================================
	// status field positions
	localparam int STS_CAP_F = 7;
	localparam int STS_CMPB_F = 6;
	localparam int STS_CMPA_F = 5;
	localparam int STS_WRAP_F = 4;
	localparam int STS_CMPB_LVL = 3;
	localparam int STS_CMPA_LVL = 2;
	localparam int STS_EDGE = 1;
	localparam int STS_CLR_A = 0;

	// service strobe bit positions
	localparam int SVC_CAP = 0;
	localparam int SVC_CMPA = 1;
	localparam int SVC_CMPB = 2;

	// ==========================================================
	// reset values
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [15:0] RST_COUNTER = 16'h0000;
	localparam logic [15:0] RST_CMP = 16'hFFFF;
	localparam logic [15:0] RST_CAPTURE = 16'h0000;
	localparam logic [15:0] CNT_ALL_ONES = 16'hFFFF;

	// ==========================================================
	// clock select codes and prescale divisors
	localparam logic [1:0] CKS_DIV4 = 2'h0;
	localparam logic [1:0] CKS_DIV8 = 2'h1;
	localparam logic [1:0] CKS_DIV32 = 2'h2;
	localparam logic [1:0] CKS_EXT = 2'h3;
	localparam int DIV4 = 4;
	localparam int DIV8 = 8;
	localparam int DIV32 = 32;

	// interrupt request bundle
	typedef struct packed {
		logic capture_irq;
		logic cmp_b_irq;
		logic cmp_a_irq;
		logic wrap_irq;
	} frtcs_irq_t;

	// transfer controller service strobes
	typedef struct packed {
		logic cmp_b;
		logic cmp_a;
		logic capture;
	} frtcs_svc_t;

endpackage

// ==== design/frtcs_timer.sv ====
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
// ==========================================================
// Notes on behaviour
// RULE1 - capture request is flag and enable
// RULE2 - compare-B request is flag and enable
// RULE3 - compare-A request is flag and enable
// RULE4 - wrap request is flag and enable
// RULE5 - compare-B pin driven only when enabled
// RULE6 - compare-A pin driven only when enabled
// RULE7 - clock select: div4, div8, div32, external
// RULE8 - software writes only clear the flags
// RULE9 - standby and reset zero status register
// RULE10 - capture sets capture flag
// RULE11 - flag cleared by zero after read
// RULE12 - transfer service clears three flags
// RULE13 - compare-B match sets its flag
// RULE14 - compare-A match sets its flag
// RULE15 - wrap to zero sets wrap flag
// RULE16 - level bit picks compare-B pin level
// RULE17 - level bit picks compare-A pin level
// RULE18 - edge bit picks capture edge
// RULE19 - clear bit governs compare-A clear
// RULE20 - compare-A match clears counter when set
// RULE21 - compare pins low until first match
// RULE22 - match fires just before counter advances
// RULE23 - sixteen bit counter advances per tick
// RULE24 - four separate level requests
module frtcs_timer
	import frtcs_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic standby,
	input wire logic ext_clk,
	input wire logic capture_pin,
	input wire frtcs_pkg::frtcs_svc_t svc,
	output logic cmp_a_pin,
	output logic cmp_b_pin,
	output frtcs_pkg::frtcs_irq_t irq
);
	import frtcs_pkg::*;

	// ==========================================================
	// state
	logic [7:0] timer_control, next_timer_control;
	logic [7:0] timer_control_status, next_timer_control_status;
	logic [15:0] up_counter, next_up_counter;
	logic [15:0] compare_reg_a, next_compare_reg_a;
	logic [15:0] compare_reg_b, next_compare_reg_b;
	logic [15:0] capture_reg, next_capture_reg;
	logic [3:0] flag_seen, next_flag_seen;
	logic [4:0] prescale, next_prescale;
	logic cmp_a_pin_q, next_cmp_a_pin_q;
	logic cmp_b_pin_q, next_cmp_b_pin_q;
	logic [2:0] ext_sync, cap_sync;
	logic [31:0] next_prdata;

	// ==========================================================
	// bus decode
	logic wr_en, rd_setup;
	logic tick, ext_rise, cap_event, match_a, match_b, wrap;
	logic [3:0] flag_set, flag_clear;

	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign wr_en = psel && penable && pwrite;
	// read data loads in setup so it stands at the access edge
	assign rd_setup = psel && !penable && !pwrite;

	// pin synchronisers, third stage only for edge detect
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ext_sync <= 3'h0;
			cap_sync <= 3'h0;
		end
		else
		begin
			ext_sync <= {ext_sync[1:0], ext_clk};
			cap_sync <= {cap_sync[1:0], capture_pin};
		end
	end

	// tick selection and event detection
	always_comb
	begin
		ext_rise = ext_sync[1] && !ext_sync[2];
		// standby restarts the prescaler
		if (standby) // RULE9
			next_prescale = 5'h00;
		else
			next_prescale = 5'(prescale + 5'h01);
		case (timer_control[CTL_CKS_HI:CTL_CKS_LO]) // RULE7
			CKS_DIV4: tick = prescale[1:0] == 2'(DIV4 - 1);
			CKS_DIV8: tick = prescale[2:0] == 3'(DIV8 - 1);
			CKS_DIV32: tick = prescale == 5'(DIV32 - 1);
			default: tick = ext_rise;
		endcase
		// match seen in the last state before advance
		match_a = tick && up_counter == compare_reg_a; // RULE22
		match_b = tick && up_counter == compare_reg_b; // RULE22
		wrap = tick && up_counter == CNT_ALL_ONES
			&& !(match_a && timer_control_status[STS_CLR_A]);
		if (timer_control_status[STS_EDGE]) // RULE18
			cap_event = cap_sync[1] && !cap_sync[2];
		else
			cap_event = !cap_sync[1] && cap_sync[2];
		flag_set = {cap_event, match_b, match_a, wrap}; // RULE10 RULE13
	end

	// flag clear sources
	always_comb
	begin
		flag_clear = 4'h0;
		if (wr_en && paddr == ADDR_STATUS)
			flag_clear = ~pwdata[7:4] & flag_seen; // RULE8 RULE11
		if (wr_en && paddr == ADDR_SERVICE)
		begin
			flag_clear[3] = flag_clear[3] || pwdata[SVC_CAP];
			flag_clear[1] = flag_clear[1] || pwdata[SVC_CMPA];
			flag_clear[2] = flag_clear[2] || pwdata[SVC_CMPB];
		end
		flag_clear[3] = flag_clear[3] || svc.capture; // RULE12
		flag_clear[1] = flag_clear[1] || svc.cmp_a; // RULE12
		flag_clear[2] = flag_clear[2] || svc.cmp_b; // RULE12
	end

	// next register values
	always_comb
	begin
		next_timer_control = timer_control;
		next_timer_control_status = timer_control_status;
		next_up_counter = up_counter;
		next_compare_reg_a = compare_reg_a;
		next_compare_reg_b = compare_reg_b;
		next_capture_reg = capture_reg;
		next_flag_seen = flag_seen;
		next_cmp_a_pin_q = cmp_a_pin_q;
		next_cmp_b_pin_q = cmp_b_pin_q;
		next_prdata = 32'h0;
		// counter advance, optional clear on compare-A
		if (match_a && timer_control_status[STS_CLR_A]) // RULE20 RULE19
			next_up_counter = RST_COUNTER;
		else if (tick)
			next_up_counter = 16'(up_counter + 16'h0001); // RULE23 RULE15
		if (cap_event)
			next_capture_reg = up_counter; // RULE10
		// compare pins take the selected level on match
		if (match_a && timer_control[CTL_CMPA_OE]) // RULE6
			next_cmp_a_pin_q = timer_control_status[STS_CMPA_LVL]; // RULE17
		if (match_b && timer_control[CTL_CMPB_OE]) // RULE5
			next_cmp_b_pin_q = timer_control_status[STS_CMPB_LVL]; // RULE16
		// software writes
		if (wr_en)
		begin
			if (paddr == ADDR_CONTROL)
				next_timer_control = pwdata[7:0];
			else if (paddr == ADDR_STATUS)
				next_timer_control_status[3:0] = pwdata[3:0];
			else if (paddr == ADDR_COUNTER)
				next_up_counter = pwdata[15:0];
			else if (paddr == ADDR_CMP_A)
				next_compare_reg_a = pwdata[15:0];
			else if (paddr == ADDR_CMP_B)
				next_compare_reg_b = pwdata[15:0];
		end
		// flags: set wins over clear
		next_timer_control_status[7:4] = (timer_control_status[7:4]
			& ~flag_clear) | flag_set; // RULE8 RULE11
		// read of a flag as one arms its clear
		if (rd_setup && paddr == ADDR_STATUS)
			next_flag_seen = timer_control_status[7:4]; // RULE11
		next_flag_seen = next_flag_seen & next_timer_control_status[7:4];
		// read data, held through the access phase
		if (rd_setup)
		begin
			if (paddr == ADDR_CONTROL)
				next_prdata = {24'h0, timer_control};
			else if (paddr == ADDR_STATUS)
				next_prdata = {24'h0, timer_control_status};
			else if (paddr == ADDR_COUNTER)
				next_prdata = {16'h0, up_counter};
			else if (paddr == ADDR_CMP_A)
				next_prdata = {16'h0, compare_reg_a};
			else if (paddr == ADDR_CMP_B)
				next_prdata = {16'h0, compare_reg_b};
			else if (paddr == ADDR_CAPTURE)
				next_prdata = {16'h0, capture_reg};
			else
				next_prdata = 32'h0;
		end
		// standby forces every register except prdata and the pin synchronisers to reset values
		if (standby) // RULE9
		begin
			next_timer_control = RST_CONTROL;
			next_timer_control_status = RST_STATUS;
			next_up_counter = RST_COUNTER;
			next_compare_reg_a = RST_CMP;
			next_compare_reg_b = RST_CMP;
			next_capture_reg = RST_CAPTURE;
			next_flag_seen = 4'h0;
			next_cmp_a_pin_q = 1'b0;
			next_cmp_b_pin_q = 1'b0;
		end
	end

	// register stage
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			timer_control <= RST_CONTROL;
			timer_control_status <= RST_STATUS; // RULE9
			up_counter <= RST_COUNTER;
			compare_reg_a <= RST_CMP;
			compare_reg_b <= RST_CMP;
			capture_reg <= RST_CAPTURE;
			flag_seen <= 4'h0;
			prescale <= 5'h00;
			cmp_a_pin_q <= 1'b0; // RULE21
			cmp_b_pin_q <= 1'b0; // RULE21
			prdata <= 32'h0;
		end
		else
		begin
			timer_control <= next_timer_control;
			timer_control_status <= next_timer_control_status;
			up_counter <= next_up_counter;
			compare_reg_a <= next_compare_reg_a;
			compare_reg_b <= next_compare_reg_b;
			capture_reg <= next_capture_reg;
			flag_seen <= next_flag_seen;
			prescale <= next_prescale;
			cmp_a_pin_q <= next_cmp_a_pin_q;
			cmp_b_pin_q <= next_cmp_b_pin_q;
			prdata <= next_prdata;
		end
	end

	// outputs
	assign cmp_a_pin = cmp_a_pin_q;
	assign cmp_b_pin = cmp_b_pin_q;
	assign irq.capture_irq = timer_control[CTL_CAP_IE]
		&& timer_control_status[STS_CAP_F]; // RULE1 RULE24
	assign irq.cmp_b_irq = timer_control[CTL_CMPB_IE]
		&& timer_control_status[STS_CMPB_F]; // RULE2 RULE24
	assign irq.cmp_a_irq = timer_control[CTL_CMPA_IE]
		&& timer_control_status[STS_CMPA_F]; // RULE3 RULE24
	assign irq.wrap_irq = timer_control[CTL_WRAP_IE]
		&& timer_control_status[STS_WRAP_F]; // RULE4 RULE24

	// ==========================================================
	// assertions
	property p_cap_irq;
		@(posedge pclk) disable iff (!presetn)
		irq.capture_irq == (timer_control[CTL_CAP_IE]
			&& timer_control_status[STS_CAP_F]);
	endproperty
	a_cap_irq: assert property (p_cap_irq) // RULE1
		else $error("capture request wrong");

	property p_cmpb_irq;
		@(posedge pclk) disable iff (!presetn)
		!timer_control[CTL_CMPB_IE] |-> !irq.cmp_b_irq;
	endproperty
	a_cmpb_irq: assert property (p_cmpb_irq) // RULE2
		else $error("compare-B request not gated");

	property p_cmpa_irq;
		@(posedge pclk) disable iff (!presetn)
		(timer_control[CTL_CMPA_IE] && timer_control_status[STS_CMPA_F])
			|-> irq.cmp_a_irq;
	endproperty
	a_cmpa_irq: assert property (p_cmpa_irq) // RULE3
		else $error("compare-A request missing");

	property p_wrap_irq;
		@(posedge pclk) disable iff (!presetn)
		irq.wrap_irq |-> timer_control_status[STS_WRAP_F];
	endproperty
	a_wrap_irq: assert property (p_wrap_irq) // RULE4
		else $error("wrap request without flag");

	property p_pin_a;
		@(posedge pclk) disable iff (!presetn)
		(match_a && timer_control[CTL_CMPA_OE] && !standby)
			|=> cmp_a_pin == $past(timer_control_status[STS_CMPA_LVL]);
	endproperty
	a_pin_a: assert property (p_pin_a) // RULE6
		else $error("compare-A pin level wrong");

	property p_pin_b_hold;
		@(posedge pclk) disable iff (!presetn)
		(!timer_control[CTL_CMPB_OE] && !standby) |=> $stable(cmp_b_pin);
	endproperty
	a_pin_b_hold: assert property (p_pin_b_hold) // RULE5
		else $error("compare-B pin moved while disabled");

	property p_wrap_set;
		@(posedge pclk) disable iff (!presetn)
		(wrap && !standby && !(wr_en && paddr == ADDR_COUNTER))
			|=> timer_control_status[STS_WRAP_F]
			&& up_counter == 16'h0000;
	endproperty
	a_wrap_set: assert property (p_wrap_set) // RULE15
		else $error("wrap flag not set");

	property p_clear_a;
		@(posedge pclk) disable iff (!presetn)
		(match_a && timer_control_status[STS_CLR_A] && !standby
			&& !(wr_en && paddr == ADDR_COUNTER)) |=> up_counter == 16'h0;
	endproperty
	a_clear_a: assert property (p_clear_a) // RULE20
		else $error("counter not cleared on compare-A");

	property p_no_sw_set;
		@(posedge pclk) disable iff (!presetn)
		(!timer_control_status[STS_CMPB_F] && !match_b)
			|=> !timer_control_status[STS_CMPB_F];
	endproperty
	a_no_sw_set: assert property (p_no_sw_set) // RULE8
		else $error("flag set without event");

	property p_standby;
		@(posedge pclk) disable iff (!presetn)
		standby |=> timer_control_status == 8'h00;
	endproperty
	a_standby: assert property (p_standby) // RULE9
		else $error("status not zero in standby");

	property p_cap_set;
		@(posedge pclk) disable iff (!presetn)
		(cap_event && !standby) |=> timer_control_status[STS_CAP_F]
			&& capture_reg == $past(up_counter);
	endproperty
	a_cap_set: assert property (p_cap_set) // RULE10
		else $error("capture flag or value wrong");

	property p_cmpb_set;
		@(posedge pclk) disable iff (!presetn)
		(match_b && !standby) |=> timer_control_status[STS_CMPB_F];
	endproperty
	a_cmpb_set: assert property (p_cmpb_set) // RULE13
		else $error("compare-B flag not set");

	property p_cmpa_set;
		@(posedge pclk) disable iff (!presetn)
		(match_a && !standby) |=> timer_control_status[STS_CMPA_F];
	endproperty
	a_cmpa_set: assert property (p_cmpa_set) // RULE14
		else $error("compare-A flag not set");

	property p_svc_clear;
		@(posedge pclk) disable iff (!presetn)
		(svc.cmp_b && !match_b && !standby)
			|=> !timer_control_status[STS_CMPB_F];
	endproperty
	a_svc_clear: assert property (p_svc_clear) // RULE12
		else $error("service did not clear compare-B flag");

	c_capture: cover property (@(posedge pclk) disable iff (!presetn)
		cap_event ##1 irq.capture_irq);
	c_match_a: cover property (@(posedge pclk) disable iff (!presetn)
		match_a && timer_control[CTL_CMPA_OE]);
	c_wrap: cover property (@(posedge pclk) disable iff (!presetn) wrap);
	c_svc: cover property (@(posedge pclk) disable iff (!presetn)
		svc.capture && timer_control_status[STS_CAP_F]);

endmodule

// ==== tb/frtcs_xfer.sv ====
`timescale 1ns/1ns
// ==========================================================
// transfer controller stand-in on the service strobes
module frtcs_xfer
	import frtcs_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic serve_en,
	input wire frtcs_pkg::frtcs_irq_t irq,
	output frtcs_pkg::frtcs_svc_t svc
);
	// one-cycle service pulse per pending request; wrap never served
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			svc <= 3'h0;
		else if (svc != 3'h0 || !serve_en)
			svc <= 3'h0;
		else
			svc <= {irq.cmp_b_irq, irq.cmp_a_irq, irq.capture_irq};
endmodule

// ==== tb/test_free_running_timer_control_status.sv ====
`timescale 1ns/1ns
// ==========================================================
// bench top
module test_free_running_timer_control_status;
	import frtcs_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, standby;
	logic ext_clk, cap_in, serve_en, pready, pslverr, pin_a, pin_b;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	frtcs_irq_t irq;
	frtcs_svc_t svc;
	int failures = 0;
	int n_tests = 0;
	int cyc = 0;
	int dv[3] = '{DIV4, DIV8, DIV32};

	frtcs_timer i_dut(.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .standby(standby), .ext_clk(ext_clk),
		.capture_pin(cap_in), .svc(svc), .cmp_a_pin(pin_a),
		.cmp_b_pin(pin_b), .irq(irq));
	frtcs_xfer i_xfer(.pclk(pclk), .presetn(presetn),
		.serve_en(serve_en), .irq(irq), .svc(svc));

	// clock
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// hang guard
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			failures++;
			summarize();
		end
	end

	// verdict
	task summarize();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// compare seen with expected
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask

	// one apb transfer; read data taken at the access edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// shorthand writes and reads
	task wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask
	task rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	// reset values, write-one ignored on flags, unmapped place
	task t_reset();
		rd(ADDR_CONTROL);
		chk("ctl", q, 32'h0);
		rd(ADDR_CMP_A);
		chk("cmpa", q, 32'hFFFF);
		chk("pins", {pin_a, pin_b, irq}, 32'h0);
		wr(ADDR_STATUS, 8'hFF);
		rd(ADDR_STATUS);
		chk("sts", q, 32'h0F);
		rd(8'h1C);
		chk("gap", q, 32'h0);
		chk("resp", {pready, pslverr}, 2'h2);
		wr(ADDR_STATUS, 8'h00);
		$display("test reset done");
	endtask

	// compare a with counter clear, level, mask and read-then-clear
	task t_cmp_a();
		wr(ADDR_COUNTER, 8'h00);
		wr(ADDR_CMP_A, 8'h05);
		wr(ADDR_STATUS, 8'h05);
		wr(ADDR_CONTROL, 8'h24);
		for (int i = 0; i < 200 && pin_a !== 1'b1; i++) @(posedge pclk);
		chk("pina", pin_a, 1'b1);
		chk("irqa", irq.cmp_a_irq, 1'b1);
		rd(ADDR_COUNTER);
		chk("clr", q <= 32'h5, 1'b1);
		wr(ADDR_CONTROL, 8'h04);
		chk("mska", irq.cmp_a_irq, 1'b0);
		apb(1'b1, ADDR_CMP_A, 32'hFFFF);
		rd(ADDR_STATUS);
		chk("fa", q[5], 1'b1);
		wr(ADDR_STATUS, 8'h05);
		rd(ADDR_STATUS);
		chk("fa0", q[5], 1'b0);
		$display("test cmp_a done");
	endtask

	// compare b and capture, then served by the transfer controller
	task t_b_cap();
		wr(ADDR_CMP_B, 8'h03);
		wr(ADDR_STATUS, 8'h0A);
		wr(ADDR_CONTROL, 8'hC8);
		wr(ADDR_COUNTER, 8'h00);
		cap_in <= 1'b1;
		for (int i = 0; i < 200 && pin_b !== 1'b1; i++) @(posedge pclk);
		chk("pinb", pin_b, 1'b1);
		rd(ADDR_STATUS);
		chk("fb", q[7:6], 2'h3);
		chk("irqb", {irq.capture_irq, irq.cmp_b_irq}, 2'h3);
		serve_en <= 1'b1;
		repeat (4) @(posedge pclk);
		serve_en <= 1'b0;
		rd(ADDR_STATUS);
		chk("svc", q[7:6], 2'h0);
		$display("test cmp_b capture done");
	endtask

	// wrap flag set, not served by the transfer controller
	task t_wrap();
		apb(1'b1, ADDR_COUNTER, 32'hFFF8);
		wr(ADDR_CONTROL, 8'h10);
		for (int i = 0; i < 100 && irq.wrap_irq !== 1'b1; i++) @(posedge pclk);
		chk("wrap", irq.wrap_irq, 1'b1);
		serve_en <= 1'b1;
		repeat (4) @(posedge pclk);
		serve_en <= 1'b0;
		wr(ADDR_STATUS, 8'h0A);
		rd(ADDR_STATUS);
		chk("fw", q[5:4], 2'h3);
		wr(ADDR_SERVICE, 8'h02);
		rd(ADDR_STATUS);
		chk("svcreg", q[5:4], 2'h1);
		$display("test wrap done");
	endtask

	// clock select codes, then standby zeroing
	task t_clk();
		for (int k = 0; k < 3; k++)
		begin
			wr(ADDR_CONTROL, k[7:0]);
			wr(ADDR_COUNTER, 8'h00);
			repeat (dv[k] * 10) @(posedge pclk);
			rd(ADDR_COUNTER);
			chk("div", q >= 9 && q <= 11, 1'b1);
		end
		wr(ADDR_CONTROL, 8'h03);
		wr(ADDR_COUNTER, 8'h00);
		repeat (6)
		begin
			repeat (4) @(posedge pclk);
			ext_clk <= ~ext_clk;
		end
		repeat (8) @(posedge pclk);
		rd(ADDR_COUNTER);
		chk("ext", q, 32'h3);
		wr(ADDR_STATUS, 8'h0F);
		standby <= 1'b1;
		@(posedge pclk);
		standby <= 1'b0;
		rd(ADDR_STATUS);
		chk("stby", q, 32'h0);
		$display("test clock standby done");
	endtask

	// main sequence
	initial
	begin
		presetn <= 1'b0;
		{psel, penable, pwrite, standby, ext_clk, cap_in, serve_en} <= 7'h0;
		paddr <= 8'h00;
		pwdata <= 32'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_cmp_a();
		t_b_cap();
		t_wrap();
		t_clk();
		summarize();
	end
endmodule
